/* logic/iorec_defines.vh */
// Constants for the ISA I/O recovery timer block
// How it works
// - At least five ISA clocks always separate consecutive forwarded I/O cycles.
// - Gap runs from the command rising edge to the next BALE falling edge.
// - Sub-cycles of one split or assembled access get no extra delay.
// - 8-bit enable (bit 6) applies the 8-bit field (bits 5:3) extra delay.
// - 8-bit field adds 1 to 7 clocks, code 000 adds eight.
// - 16-bit enable (bit 2) applies the 16-bit field (bits 1:0) extra delay.
// - 16-bit field adds 1 to 3 clocks, code 00 adds four.
// - Recovery register resets to 56h, both extras enabled, two clocks each.
// - Bit 7 of the recovery register always reads back as zero.
// - ISA clock is the host bus clock divided by a programmable integer.
`ifndef IOREC_DEFINES_VH
`define IOREC_DEFINES_VH

`define IOREC_ADDR_W        8
`define IOREC_OFS_RECOV     8'h4C
`define IOREC_OFS_DIV       8'h50
`define IOREC_OFS_STATUS    8'h54

`define IOREC_RECOV_RST     8'h56
`define IOREC_DIV_RST       8'h04
`define IOREC_DIV_MIN       8'h02

`define IOREC_B8_EN         6
`define IOREC_B8_HI         5
`define IOREC_B8_LO         3
`define IOREC_B16_EN        2
`define IOREC_B16_HI        1
`define IOREC_B16_LO        0
`define IOREC_RSVD_BIT      7

`define IOREC_MIN_GAP       5'h05
`define IOREC_B8_ZERO_ADD   5'h08
`define IOREC_B16_ZERO_ADD  5'h04
`define IOREC_BALE_LEAD     5'h02
`define IOREC_CMD_TICKS     4'h3
`define IOREC_REC_SAT       4'hF

`define IOREC_HTRANS_NSEQ   2'h2
`define IOREC_HRESP_OKAY    1'h0

`endif

/* logic/iorec_clkdiv.v */
// ISA clock divider: tick and clock level from the host bus clock
`timescale 1ns/10ps
`include "iorec_defines.vh"
module iorec_clkdiv #(
  parameter DIV_W = 8
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [DIV_W-1:0] div_val,
  output wire             tick,
  output reg              sysclk_ff
);
  reg  [DIV_W-1:0] cnt_ff;
  reg  [DIV_W-1:0] nxt_cnt;
  wire [DIV_W-1:0] div_eff;
  wire [DIV_W-1:0] half;

  // Divisors below the minimum behave as the minimum
  assign div_eff = (div_val < `IOREC_DIV_MIN) ? `IOREC_DIV_MIN : div_val;
  assign half    = div_eff >> 1;
  // Restart at once if a smaller divisor leaves the count past its end
  assign tick    = (cnt_ff >= div_eff - {{(DIV_W-1){1'b0}}, 1'b1});

  always @* begin
    nxt_cnt = tick ? {DIV_W{1'b0}} : cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff    <= {DIV_W{1'b0}};
      sysclk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (tick) begin
        sysclk_ff <= 1'b1;
      end else if (cnt_ff == half - {{(DIV_W-1){1'b0}}, 1'b1}) begin
        sysclk_ff <= 1'b0;
      end
    end
  end
endmodule

/* logic/iorec_top.v */
// ISA I/O recovery timer with AHB-Lite register slave
`timescale 1ns/10ps
`include "iorec_defines.vh"
module iorec_top #(
  parameter DIV_W = 8
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  output reg  [31:0] hrdata_ff,
  input  wire        io_req,
  input  wire        io_wide,
  input  wire        io_sub,
  input  wire        io_write,
  output reg         io_done_ff,
  output reg         bale_ff,
  output reg         ior_n_ff,
  output reg         iow_n_ff,
  output wire        sysclk
);
  localparam ST_IDLE = 3'b001;
  localparam ST_BALE = 3'b010;
  localparam ST_CMD  = 3'b100;

  reg  [2:0]       state_ff;
  reg  [2:0]       nxt_state;
  reg  [7:0]       recov_ff;
  reg  [7:0]       nxt_recov;
  reg  [DIV_W-1:0] div_ff;
  reg  [DIV_W-1:0] nxt_div;
  reg              wr_pend_ff;
  reg  [7:0]       wr_addr_ff;
  reg  [3:0]       rec_cnt_ff;
  reg  [3:0]       nxt_rec_cnt;
  reg  [3:0]       cmd_cnt_ff;
  reg  [3:0]       nxt_cmd_cnt;
  reg              last_wide_ff;
  reg              cur_wide_ff;
  reg              cur_write_ff;
  reg  [4:0]       extra;
  reg  [31:0]      nxt_rdata;
  wire             tick;
  wire             addr_take;
  wire [7:0]       addr_lo;
  wire [4:0]       need;
  wire             gap_ok;
  wire             start;
  wire             cmd_end;

  iorec_clkdiv #(
    .DIV_W     (DIV_W)
  ) u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_val   (div_ff),
    .tick      (tick),
    .sysclk_ff (sysclk)
  );

  // Bus address phase
  assign addr_take = hsel & hready & (htrans == `IOREC_HTRANS_NSEQ);
  assign addr_lo   = haddr[7:0];

  // Register writes land in the data phase
  always @* begin
    nxt_recov = recov_ff;
    nxt_div   = div_ff;
    if (wr_pend_ff) begin
      if (wr_addr_ff == `IOREC_OFS_RECOV) begin
        nxt_recov = {1'b0, hwdata[6:0]};
      end else if (wr_addr_ff == `IOREC_OFS_DIV) begin
        nxt_div = hwdata[DIV_W-1:0];
      end
    end
  end

  // Read data taken from next values so a write just before is seen
  always @* begin
    nxt_rdata = 32'h00000000;
    if (addr_lo == `IOREC_OFS_RECOV) begin
      nxt_rdata[7:0] = nxt_recov;
    end else if (addr_lo == `IOREC_OFS_DIV) begin
      nxt_rdata[DIV_W-1:0] = nxt_div;
    end else if (addr_lo == `IOREC_OFS_STATUS) begin
      nxt_rdata[0]   = (state_ff != ST_IDLE);
      nxt_rdata[1]   = last_wide_ff;
      nxt_rdata[2]   = gap_ok;
      nxt_rdata[7:4] = rec_cnt_ff;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `IOREC_HRESP_OKAY;
      hrdata_ff    <= 32'h00000000;
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      recov_ff     <= `IOREC_RECOV_RST;
      div_ff       <= `IOREC_DIV_RST;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `IOREC_HRESP_OKAY;
      wr_pend_ff   <= addr_take & hwrite;
      if (addr_take) begin
        wr_addr_ff <= addr_lo;
      end
      if (addr_take & ~hwrite) begin
        hrdata_ff <= nxt_rdata;
      end
      recov_ff <= nxt_recov;
      div_ff   <= nxt_div;
    end
  end

  // Extra recovery chosen by the width of the cycle just finished
  always @* begin
    extra = 5'h00;
    if (io_sub) begin
      extra = 5'h00;
    end else if (last_wide_ff) begin
      if (recov_ff[`IOREC_B16_EN]) begin
        if (recov_ff[`IOREC_B16_HI:`IOREC_B16_LO] == 2'h0) begin
          extra = `IOREC_B16_ZERO_ADD;
        end else begin
          extra = {3'h0, recov_ff[`IOREC_B16_HI:`IOREC_B16_LO]};
        end
      end
    end else begin
      if (recov_ff[`IOREC_B8_EN]) begin
        if (recov_ff[`IOREC_B8_HI:`IOREC_B8_LO] == 3'h0) begin
          extra = `IOREC_B8_ZERO_ADD;
        end else begin
          extra = {2'h0, recov_ff[`IOREC_B8_HI:`IOREC_B8_LO]};
        end
      end
    end
  end

  // BALE rises one tick before its falling edge, which ends the gap
  assign need    = `IOREC_MIN_GAP + extra;
  assign gap_ok  = ({1'b0, rec_cnt_ff} + `IOREC_BALE_LEAD) >= need;
  assign start   = tick & (state_ff == ST_IDLE) & io_req & gap_ok;
  assign cmd_end = tick & (state_ff == ST_CMD) & (cmd_cnt_ff == 4'h0);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_BALE;
        end
      end
      ST_BALE: begin
        if (tick) begin
          nxt_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmd_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    nxt_cmd_cnt = cmd_cnt_ff;
    if (tick & (state_ff == ST_BALE)) begin
      nxt_cmd_cnt = `IOREC_CMD_TICKS - 4'h1;
    end else if (tick & (state_ff == ST_CMD) & (cmd_cnt_ff != 4'h0)) begin
      nxt_cmd_cnt = cmd_cnt_ff - 4'h1;
    end
  end

  // Recovery count restarts at the command rising edge, saturates
  always @* begin
    nxt_rec_cnt = rec_cnt_ff;
    if (cmd_end) begin
      nxt_rec_cnt = 4'h0;
    end else if (tick & (rec_cnt_ff != `IOREC_REC_SAT)) begin
      nxt_rec_cnt = rec_cnt_ff + 4'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= ST_IDLE;
      rec_cnt_ff   <= `IOREC_REC_SAT;
      cmd_cnt_ff   <= 4'h0;
      last_wide_ff <= 1'b0;
      cur_wide_ff  <= 1'b0;
      cur_write_ff <= 1'b0;
      bale_ff      <= 1'b0;
      ior_n_ff     <= 1'b1;
      iow_n_ff     <= 1'b1;
      io_done_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      rec_cnt_ff <= nxt_rec_cnt;
      cmd_cnt_ff <= nxt_cmd_cnt;
      io_done_ff <= cmd_end;
      if (start) begin
        cur_wide_ff  <= io_wide;
        cur_write_ff <= io_write;
        bale_ff      <= 1'b1;
      end
      if (tick & (state_ff == ST_BALE)) begin
        bale_ff  <= 1'b0;
        ior_n_ff <= cur_write_ff;
        iow_n_ff <= ~cur_write_ff;
      end
      if (cmd_end) begin
        ior_n_ff     <= 1'b1;
        iow_n_ff     <= 1'b1;
        last_wide_ff <= cur_wide_ff;
      end
    end
  end
endmodule

/* tb/iorec_chk.sv */
// Port assertions for the ISA I/O recovery timer
`timescale 1ns/10ps
module iorec_chk (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire io_write,
  input wire io_done_ff,
  input wire bale_ff,
  input wire ior_n_ff,
  input wire iow_n_ff,
  input wire sysclk
);
  logic       cmd_hi_ff;
  logic       sys_ff;
  logic [7:0] gap_cnt_ff;
  logic [7:0] isa_cnt_ff;
  wire        cmd_hi = ior_n_ff & iow_n_ff;
  wire        cmd_rise = cmd_hi & ~cmd_hi_ff;
  // Host clocks and ISA clock rises since the command rose, saturating
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_hi_ff  <= 1'b1;
      sys_ff     <= 1'b0;
      gap_cnt_ff <= 8'hFF;
      isa_cnt_ff <= 8'hFF;
    end else begin
      cmd_hi_ff <= cmd_hi;
      sys_ff    <= sysclk;
      if (cmd_rise)
        gap_cnt_ff <= 8'h00;
      else if (gap_cnt_ff != 8'hFF)
        gap_cnt_ff <= gap_cnt_ff + 8'h01;
      if (cmd_rise)
        isa_cnt_ff <= 8'h00;
      else if (sysclk && !sys_ff && isa_cnt_ff != 8'hFF)
        isa_cnt_ff <= isa_cnt_ff + 8'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cmd_held;
    !ior_n_ff [*5];
  endsequence
  sequence s_wcmd_held;
    !iow_n_ff [*5];
  endsequence
  // BALE falls on an ISA clock rise, which is not yet in the count
  sequence s_isa_gap;
    $rose(sysclk) && isa_cnt_ff >= 8'h04;
  endsequence
  a_ready_high: assert property (hreadyout_ff)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_ff)
    else $error("response not okay");
  a_cmd_single: assert property (ior_n_ff | iow_n_ff)
    else $error("both commands low");
  a_bale_idle_cmd: assert property (bale_ff |-> cmd_hi)
    else $error("bale during command");
  a_bale_width: assert property ($rose(bale_ff) |=> bale_ff)
    else $error("bale too short");
  a_read_length: assert property ($fell(ior_n_ff) |=> s_cmd_held)
    else $error("read command too short");
  a_write_length: assert property ($fell(iow_n_ff) |=> s_wcmd_held)
    else $error("write command too short");
  a_read_dir: assert property (!io_write |-> iow_n_ff)
    else $error("write command during read request");
  a_write_dir: assert property (io_write |-> ior_n_ff)
    else $error("read command during write request");
  a_done_pulse: assert property (io_done_ff |=> !io_done_ff)
    else $error("done longer than one cycle");
  a_done_follows: assert property ($rose(cmd_hi) |-> io_done_ff)
    else $error("done missing after command");
  a_min_gap: assert property ($fell(bale_ff) |-> gap_cnt_ff >= 8'h09)
    else $error("recovery gap too short");
  a_isa_gap: assert property ($fell(bale_ff) |-> s_isa_gap)
    else $error("recovery gap under five ISA clocks");
endmodule
bind iorec_top iorec_chk iorec_chk_inst (.hclk(hclk), .hresetn(hresetn),
  .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .io_write(io_write),
  .io_done_ff(io_done_ff), .bale_ff(bale_ff), .ior_n_ff(ior_n_ff),
  .iow_n_ff(iow_n_ff), .sysclk(sysclk));

/* tb/iorec_slave.sv */
// ISA I/O slave model that measures the recovery gap in host clocks
`timescale 1ns/10ps
module iorec_slave (
  input  wire       hclk,
  input  wire       bale,
  input  wire       ior_n,
  input  wire       iow_n,
  output reg  [7:0] gap_hclk
);
  reg       cmd_q = 1'b1;
  reg       bale_q = 1'b0;
  reg [7:0] cnt = 8'h00;
  initial gap_hclk = 8'h00;
  always @(posedge hclk) begin
    cmd_q <= ior_n & iow_n;
    bale_q <= bale;
    cnt <= (ior_n & iow_n & !cmd_q) ? 8'h01 : cnt + 8'h01;
    if (bale_q && !bale)
      gap_hclk <= cnt;
  end
endmodule

/* tb/isa_io_recovery_delay_test.sv */
// Self-checking bench for the ISA I/O recovery timer
`timescale 1ns/10ps
module isa_io_recovery_delay_test;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic        io_req = 0, io_wide = 0, io_sub = 0, io_write = 0;
  logic        io_done, bale, ior_n, iow_n;
  logic [7:0]  gap;
  int          mismatches = 0, n_checks = 0, dv = 4;
  iorec_top iorec_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout_ff(hready),
    .hresp_ff(), .hrdata_ff(hrdata), .io_req(io_req), .io_wide(io_wide),
    .io_sub(io_sub), .io_write(io_write), .io_done_ff(io_done),
    .bale_ff(bale), .ior_n_ff(ior_n), .iow_n_ff(iow_n), .sysclk());
  iorec_slave iorec_slave_inst (.hclk(hclk), .bale(bale), .ior_n(ior_n),
    .iow_n(iow_n), .gap_hclk(gap));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic io_cyc(logic w, logic s);
    @(posedge hclk);
    io_req <= 1'b1;
    io_wide <= w;
    io_sub <= s;
    io_write <= ~io_write;
    do @(posedge hclk); while (io_done !== 1'b1);
    io_req <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] r;
    bus(0, 8'h4C, 32'h0, r);
    check(r, 32'h56);
    bus(0, 8'h54, 32'h0, r);
    check(r, 32'hF4);
    bus(1, 8'h4C, 32'hFF, r);
    bus(0, 8'h4C, 32'h0, r);
    check(r, 32'h7F);
    bus(1, 8'h60, 32'hFF, r);
    bus(0, 8'h60, 32'h0, r);
    check(r, 32'h0);
    bus(0, 8'h50, 32'h0, r);
    check(r, 32'h4);
    $display("test regs done");
  endtask
  task automatic t_gap(logic [7:0] cfg, logic w1, logic w2, logic s, int e);
    logic [31:0] r;
    bus(1, 8'h4C, {24'h0, cfg}, r);
    io_cyc(w1, 1'b0);
    io_cyc(w2, s);
    repeat (4) @(posedge hclk);
    check({24'h0, gap}, e * dv);
    $display("test gap cfg %h done", cfg);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #4 hclk = ~hclk;
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_gap(8'h56, 0, 0, 0, 7);
    t_gap(8'h56, 1, 1, 0, 7);
    bus(1, 8'h50, 32'h2, r);
    bus(0, 8'h50, 32'h0, r);
    check(r, 32'h2);
    dv = 2;
    for (int c = 0; c < 8; c++) begin
      t_gap(8'h40 | 8'(c << 3), 0, 0, 0, c ? 5 + c : 13);
    end
    for (int c = 0; c < 4; c++) begin
      t_gap(8'h04 | 8'(c), 1, 1, 0, c ? 5 + c : 9);
    end
    t_gap(8'h3B, 0, 0, 0, 5);
    t_gap(8'h3B, 1, 1, 0, 5);
    t_gap(8'h56, 0, 0, 1, 5);
    t_gap(8'h7D, 1, 0, 0, 6);
    t_gap(8'h7D, 0, 1, 0, 12);
    close_out();
  end
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
endmodule
